// File: bench/hch_channel_ctrl_chk.sv
// port checks for the channel control block
`timescale 1ns/1ps
module hch_channel_ctrl_chk #(
  parameter int NUM_CH = 6
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic [NUM_CH-1:0] channel_input_pin,
  input wire logic [NUM_CH-1:0] inverse_current,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic [NUM_CH-1:0] channel_output_pin
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence quiet_s;
    spi_cs_n && $stable(channel_input_pin) && !(|inverse_current);
  endsequence
  a_reset_out_low: assert property (
    $past(srst) |-> channel_output_pin == '0 && !spi_miso_oe)
    else $error("outputs not cleared by reset");
  a_inverse_hold: assert property (
    (&inverse_current)[*4] |=> $stable(channel_output_pin))
    else $error("output moved under inverse current");
  a_quiet_out_stable: assert property (
    quiet_s[*8] |=> $stable(channel_output_pin))
    else $error("output moved without cause");
  a_oe_on_select: assert property (
    $fell(spi_cs_n) |-> ##[3:5] spi_miso_oe)
    else $error("miso not driven after select");
  a_oe_off_deselect: assert property (
    $rose(spi_cs_n) |-> ##[2:5] !spi_miso_oe)
    else $error("miso still driven after deselect");
  a_oe_in_frame: assert property (
    (!spi_cs_n)[*6] |-> spi_miso_oe)
    else $error("miso not driven in frame");
  a_oe_idle_low: assert property (
    spi_cs_n[*6] |-> !spi_miso_oe)
    else $error("miso driven while idle");
  a_miso_hold_high: assert property (
    spi_sclk[*3] |-> $stable(spi_miso))
    else $error("miso moved while sclk high");
endmodule : hch_channel_ctrl_chk

// File: bench/hch_spi_master.sv
// spi master model that runs mode 0 frames into the block
`timescale 1ns/1ps
module hch_spi_master (
  input wire logic clock,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // eight bits msb first, five clocks per sclk phase
  // nb below eight gives a cut frame that the block must ignore
  task automatic xfer(input logic [7:0] tx, input int nb,
                      output logic [7:0] rx);
    spi_cs_n <= 1'b0;
    repeat (6) @(posedge clock);
    for (int i = 7; i > 7 - nb; i--) begin
      spi_mosi <= tx[i];
      repeat (5) @(posedge clock);
      spi_sclk <= 1'b1;
      rx[i] = spi_miso;
      repeat (5) @(posedge clock);
      spi_sclk <= 1'b0;
    end
    repeat (5) @(posedge clock);
    spi_cs_n <= 1'b1;
    // released data line shows the inverse of its last bit
    spi_mosi <= ~spi_mosi;
    repeat (8) @(posedge clock);
  endtask : xfer
endmodule : hch_spi_master

// File: bench/tb.sv
// self-checking bench for the channel control block
`timescale 1ns/1ps
module tb;
  logic clock, srst, sclk, cs_n, mosi, miso, oe;
  logic [5:0] pins, inv, outp;
  logic [4:0] dyn;
  logic [7:0] rx;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  hch_channel_ctrl dut_u (.clock(clock), .srst(srst), .ce(1'b1),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .channel_input_pin(pins), .inverse_current(inv),
    .dyn_shutdown(dyn), .spi_miso(miso), .spi_miso_oe(oe),
    .channel_output_pin(outp));
  hch_spi_master spi_u (.clock(clock), .spi_miso(miso),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic frame(input logic [7:0] tx, input logic [7:0] exp);
    spi_u.xfer(tx, 8, rx);
    chk(exp, rx);
  endtask : frame
  task automatic cut_frame(input logic [7:0] tx);
    spi_u.xfer(tx, 7, rx);
  endtask : cut_frame
  task automatic out_is(input logic [5:0] exp);
    repeat (8) @(posedge clock);
    chk({2'h0, exp}, {2'h0, outp});
  endtask : out_is
  task automatic complete_run;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    srst = 1'b1;
    pins = 6'h00;
    inv = 6'h00;
    dyn = 5'h00;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    frame(8'hAA, 8'h00);
    out_is(6'h2A);
    frame(8'h00, 8'h00);
    frame(8'h50, 8'h2A);
    pins <= 6'h15;
    out_is(6'h3F);
    frame(8'hD8, 8'h00);
    out_is(6'h00);
    frame(8'h50, 8'h00);
    frame(8'hAA, 8'h08);
    pins <= 6'h3E;
    out_is(6'h2A);
    inv <= 6'h3F;
    repeat (4) @(posedge clock);
    pins <= 6'h00;
    out_is(6'h2A);
    inv <= 6'h02;
    dyn <= 5'h03;
    out_is(6'h02);
    frame(8'hAA, 8'h01);
    dyn <= 5'h00;
    inv <= 6'h00;
    frame(8'hAA, 8'h01);
    frame(8'hAA, 8'h00);
    frame(8'hF8, 8'h00);
    frame(8'h50, 8'h00);
    frame(8'h00, 8'h08);
    cut_frame(8'hC0);
    frame(8'h00, 8'h2A);
    complete_run();
  end
endmodule : tb
bind hch_channel_ctrl hch_channel_ctrl_chk #(.NUM_CH(NUM_CH)) chk_u (
  .clock, .srst, .spi_sclk, .spi_cs_n, .channel_input_pin,
  .inverse_current, .spi_miso, .spi_miso_oe, .channel_output_pin);

// File: verilog/hch_channel_ctrl.sv
// channel command, input gating and error flag logic with spi access
`timescale 1ns/1ps
`include "hch_params.svh"
module hch_channel_ctrl
  import hch_pkg::*;
#(
  parameter int NUM_CH = `HCH_NUM_CH,
  parameter int NUM_DYN = `HCH_NUM_DYN,
  parameter int FRAME_BITS = `HCH_FRAME_BITS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic [NUM_CH-1:0] channel_input_pin,
  input wire logic [NUM_CH-1:0] inverse_current,
  input wire logic [NUM_DYN-1:0] dyn_shutdown,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic [NUM_CH-1:0] channel_output_pin
);

  localparam int SW = 3 + 2 * NUM_CH + NUM_DYN;
  localparam logic [SW-1:0] SYNC_RST = {1'b0, 1'b1, {(SW - 2){1'b0}}};
  localparam logic [`HCH_CNT_W-1:0] FRAME_LEN = `HCH_CNT_W'(FRAME_BITS);

  // register selected by a frame; bank 0 is the command register
  function automatic hch_rsp_t reg_decode(input logic [7:0] f);
    logic [1:0] addr;
    addr = {f[`HCH_POS_AD], f[`HCH_POS_DR]};
    if (!f[`HCH_POS_RB]) begin
      reg_decode = HCH_RSP_CMD;
    end else if (addr == `HCH_ADDR_GATE) begin
      reg_decode = HCH_RSP_CFG;
    end else begin
      reg_decode = HCH_RSP_DIAG;
    end
  endfunction : reg_decode

  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic [NUM_CH-1:0] in_s;
  logic [NUM_CH-1:0] inv_s;
  logic [NUM_DYN-1:0] dyn_s;

  hch_sync #(
    .W(SW),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .d({spi_sclk, spi_cs_n, spi_mosi, channel_input_pin, inverse_current,
        dyn_shutdown}),
    .q({sclk_s, cs_n_s, mosi_s, in_s, inv_s, dyn_s})
  );

  hch_state_t state;
  hch_state_t next_state;
  logic sclk_d;
  logic cs_d;
  logic [`HCH_CNT_W-1:0] bit_cnt;
  logic [FRAME_BITS-1:0] rx_shift;
  logic [FRAME_BITS-1:0] tx_shift;
  hch_rsp_t resp_sel;
  logic resp_was_diag;
  logic [NUM_CH-1:0] channel_command_bit;
  logic input_gating_sel;
  logic [NUM_DYN-1:0] err_flag;

  // edge detection on the synchronised spi lines
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire cs_fall = ~cs_n_s & cs_d;

  wire in_idle = (state == HCH_IDLE);
  wire in_shift = (state == HCH_SHIFT);
  wire in_exec = (state == HCH_EXEC);
  wire frame_start = in_idle & cs_fall;
  wire frame_end = in_shift & cs_n_s;
  wire frame_ok = (bit_cnt == FRAME_LEN);

  // command decode of the completed frame
  wire is_write = rx_shift[`HCH_POS_WR];
  wire hch_rsp_t rx_sel = reg_decode(rx_shift[7:0]);
  wire wr_cmd = in_exec & is_write & (rx_sel == HCH_RSP_CMD);
  wire wr_cfg = in_exec & is_write & (rx_sel == HCH_RSP_CFG);
  wire diag_read = in_exec & resp_was_diag;

  // response word for the frame now starting
  wire [FRAME_BITS-1:0] word_cmd = FRAME_BITS'(channel_command_bit);
  wire [FRAME_BITS-1:0] word_cfg =
    FRAME_BITS'({input_gating_sel, 3'h0});
  wire [FRAME_BITS-1:0] word_diag = FRAME_BITS'(err_flag);
  wire [FRAME_BITS-1:0] rsp_word =
    (resp_sel == HCH_RSP_CMD) ? word_cmd :
    (resp_sel == HCH_RSP_CFG) ? word_cfg : word_diag;

  always_comb begin
    next_state = state;
    unique case (state)
      HCH_IDLE: begin
        if (cs_fall) begin
          next_state = HCH_SHIFT;
        end
      end
      HCH_SHIFT: begin
        if (cs_n_s) begin
          next_state = frame_ok ? HCH_EXEC : HCH_IDLE;
        end
      end
      HCH_EXEC: begin
        next_state = HCH_IDLE;
      end
      default: begin
        next_state = HCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= HCH_IDLE;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      sclk_d <= sclk_s;
      cs_d <= cs_n_s;
    end
  end

  // receive path: mosi sampled on rising sclk, count saturates
  always_ff @(posedge clock) begin
    if (srst) begin
      bit_cnt <= '0;
      rx_shift <= '0;
    end else if (ce) begin
      if (frame_start) begin
        bit_cnt <= '0;
      end else if (in_shift && sclk_rise) begin
        rx_shift <= {rx_shift[FRAME_BITS-2:0], mosi_s};
        if (bit_cnt != '1) begin
          bit_cnt <= bit_cnt + `HCH_CNT_W'(1);
        end
      end
    end
  end

  // transmit path: first bit at select, next bits on falling sclk
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_shift <= '0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
      resp_was_diag <= 1'b0;
    end else if (ce) begin
      if (frame_start) begin
        spi_miso <= rsp_word[FRAME_BITS-1];
        tx_shift <= {rsp_word[FRAME_BITS-2:0], 1'b0};
        spi_miso_oe <= 1'b1;
        resp_was_diag <= (resp_sel == HCH_RSP_DIAG);
      end else if (frame_end) begin
        // deselect wins over a late sclk fall so miso is always released
        spi_miso <= 1'b0;
        spi_miso_oe <= 1'b0;
      end else if (in_shift && sclk_fall) begin
        spi_miso <= tx_shift[FRAME_BITS-1];
        tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // registers written by complete frames; reads choose next response
  always_ff @(posedge clock) begin
    if (srst) begin
      channel_command_bit <= `HCH_RST_CMD;
      input_gating_sel <= `HCH_RST_GATE;
      resp_sel <= HCH_RSP_DIAG;
    end else if (ce) begin
      if (wr_cmd) begin
        channel_command_bit <= rx_shift[NUM_CH-1:0];
      end
      if (wr_cfg) begin
        input_gating_sel <= rx_shift[`HCH_POS_GATE];
      end
      if (in_exec) begin
        resp_sel <= is_write ? HCH_RSP_DIAG : rx_sel;
      end
    end
  end

  // per-channel output combination and error flags
  logic [NUM_CH-1:0] next_out;
  logic [NUM_DYN-1:0] next_err;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      wire or_mode = channel_input_pin_or(gi);
      wire drive = input_gating_sel ?
        (channel_command_bit[gi] & in_s[gi]) :
        or_mode;
      // inverse current freezes the channel in its present state
      assign next_out[gi] = inv_s[gi] ? channel_output_pin[gi] : drive;
    end
    for (gi = 0; gi < NUM_DYN; gi++) begin : g_err
      // shutdown sets again over the read clear; inverse current wins
      assign next_err[gi] = inv_s[gi] ? 1'b0 :
        (dyn_s[gi] | (err_flag[gi] & ~diag_read));
    end
  endgenerate

  function automatic logic channel_input_pin_or(input int idx);
    channel_input_pin_or = channel_command_bit[idx] | in_s[idx];
  endfunction : channel_input_pin_or

  always_ff @(posedge clock) begin
    if (srst) begin
      channel_output_pin <= '0;
      err_flag <= '0;
    end else if (ce) begin
      channel_output_pin <= next_out;
      err_flag <= next_err;
    end
  end

endmodule : hch_channel_ctrl

// File: verilog/hch_params.svh
// constants for the six-channel high-side channel control block
// Overview of operation
// - six readable writable command bits, 1 means on
// - gate bit clear: channel on if pin or command
// - gate bit set: channel on if pin and command
// - inverse current clears error flag, channels 0-4
// - inverse current keeps channel's present on/off state
// - floating channel input pin reads as low; the code has no pull-down, srst alone zeroes the synchroniser pin stages
// - reading error flag clears it unless shutdown persists
`ifndef HCH_PARAMS_SVH
`define HCH_PARAMS_SVH

`define HCH_NUM_CH 6
`define HCH_NUM_DYN 5
`define HCH_FRAME_BITS 8
`define HCH_CNT_W 4

// frame field positions
`define HCH_POS_WR 7
`define HCH_POS_RB 6
`define HCH_POS_AD 5
`define HCH_POS_DR 4
`define HCH_POS_GATE 3

// bank 1 address of the gating configuration register
`define HCH_ADDR_GATE 2'h1

// reset values
`define HCH_RST_CMD 6'h00
`define HCH_RST_GATE 1'h0

`endif

// File: verilog/hch_pkg.sv
// types for the high-side channel control block
package hch_pkg;

  typedef enum logic [2:0] {
    HCH_IDLE  = 3'b001,
    HCH_SHIFT = 3'b010,
    HCH_EXEC  = 3'b100
  } hch_state_t;

  typedef enum logic [1:0] {
    HCH_RSP_DIAG = 2'h0,
    HCH_RSP_CMD  = 2'h1,
    HCH_RSP_CFG  = 2'h2
  } hch_rsp_t;

endpackage : hch_pkg

// File: verilog/hch_sync.sv
// two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module hch_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1;

  // reset value of zero loads the channel pin stages during srst only; an open pin is not pulled low
  always_ff @(posedge clock) begin
    if (srst) begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule : hch_sync
